/* File: spa_pkg.sv */
package spa_pkg;
   // register indexes as printed; byte address is four times the index
   localparam logic [15:0] SPA_IDX_STATUS  = 16'h1FB9;
   localparam logic [15:0] SPA_IDX_TXBUF   = 16'h1FBA;
   localparam logic [15:0] SPA_IDX_CONTROL = 16'h1FBB;
   localparam logic [15:0] SPA_IDX_RXBUF   = 16'h1FB8;
   localparam logic [15:0] SPA_IDX_BAUD    = 16'h1FBC;
   localparam logic [7:0]  SPA_STATUS_RST  = 8'h0B;
   localparam logic [7:0]  SPA_CONTROL_RST = 8'hC0;
   localparam logic [15:0] SPA_BAUD_RST    = 16'h8000;
   // control field positions
   localparam int SPA_C_PAR = 5;
   localparam int SPA_C_TB8 = 4;
   localparam int SPA_C_REN = 3;
   localparam int SPA_C_PEN = 2;
   // status field positions, then the baud clock source select bit
   localparam int SPA_S_RB8 = 7;
   localparam int SPA_S_RI  = 6;
   localparam int SPA_S_TI  = 5;
   localparam int SPA_S_FE  = 4;
   localparam int SPA_S_TXE = 3;
   localparam int SPA_S_OE  = 2;
   localparam int SPA_BAUD_CLOCK_SOURCE_SELECT = 15;
   // samples per bit in async modes; sample taken at the middle one
   localparam logic [3:0] SPA_OVS_LAST = 4'hF;
   localparam logic [3:0] SPA_OVS_MID  = 4'h7;
   typedef enum logic [1:0] {SPA_M0, SPA_M1, SPA_M2, SPA_M3} spa_mode_e;
endpackage

/* File: spa_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface spa_tick_if;
   logic        tick;
   logic [15:0] baud;
   logic        sync_mode;
   logic        ext_edge;
   modport gen (output tick, input baud, input sync_mode, input ext_edge);
   modport use_(input tick, output baud, output sync_mode, output ext_edge);
endinterface
`default_nettype wire

/* File: spa_baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none
// divider: async tick is 16x bit rate, sync tick is 2x bit rate (one tick per
// half bit), so the formulas land on the documented rates
module spa_baud_gen
   import spa_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic rstn_i,
   spa_tick_if.gen   tk
);
   logic [14:0] cnt_r;
   logic [14:0] cnt_nxt;
   logic        tick_r;
   logic        tick_nxt;
   logic [14:0] bv;
   logic        src_edge;

   // both edges of the external pin count, so one tick per bv edges gives
   // bv pin periods per mode 0 bit and 8*bv per async bit
   always_comb
   begin
      bv       = tk.baud[14:0];
      src_edge = tk.baud[SPA_BAUD_CLOCK_SOURCE_SELECT] ? 1'b1 : tk.ext_edge;
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (src_edge)
      begin
         if (tk.baud[SPA_BAUD_CLOCK_SOURCE_SELECT])
         begin
            // oscillator divides by bv+1 per tick
            if (cnt_r >= bv)
            begin
               cnt_nxt  = 15'h0000;
               tick_nxt = 1'b1;
            end
            else
               cnt_nxt = cnt_r + 15'h0001;
         end
         else
         begin
            // external clock divides by bv per tick (bv 0 treated as 1)
            if (cnt_r + 15'h0001 >= bv)
            begin
               cnt_nxt  = 15'h0000;
               tick_nxt = 1'b1;
            end
            else
               cnt_nxt = cnt_r + 15'h0001;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_r  <= 15'h0000;
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tk.tick = tick_r;
endmodule
`default_nettype wire

/* File: spa_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
module spa_serial_port
   import spa_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rxd_i,
   output logic             rxd_o,
   output logic             rxd_oe_o,
   output logic             txd_o,
   input  wire logic        ext_clk_i
);
   // ==========================================================
   // input synchronisers
   logic rx_s1_r, rx_s2_r, rx_s3_r, ex_s1_r, ex_s2_r, ex_s3_r;
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
         rx_s3_r <= 1'b1;
         ex_s1_r <= 1'b0;
         ex_s2_r <= 1'b0;
         ex_s3_r <= 1'b0;
      end
      else
      begin
         rx_s1_r <= rxd_i;
         rx_s2_r <= rx_s1_r;
         rx_s3_r <= rx_s2_r;
         ex_s1_r <= ext_clk_i;
         ex_s2_r <= ex_s1_r;
         ex_s3_r <= ex_s2_r;
      end
   end

   // ==========================================================
   // registers and bus
   logic [7:0]  ctl_r, ctl_nxt, sts_r, sts_nxt, txb_r, txb_nxt;
   logic [7:0]  rxb_r, rxb_nxt;
   logic [15:0] baud_r, baud_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        acc, wr, rd, hit;
   logic [15:0] idx;
   spa_mode_e   mode;
   logic        ren, parity_enable_bit, sync;
   spa_tick_if  tk();

   assign acc     = psel & penable;
   assign idx     = paddr[17:2];
   assign wr      = acc & pwrite;
   assign rd      = acc & ~pwrite;
   assign hit     = (idx == SPA_IDX_STATUS) | (idx == SPA_IDX_TXBUF) |
                    (idx == SPA_IDX_CONTROL) | (idx == SPA_IDX_RXBUF) |
                    (idx == SPA_IDX_BAUD);
   assign pready  = 1'b1;
   assign pslverr = acc & (~hit | (paddr[1:0] != 2'b00));
   assign prdata  = prdata_r;
   assign mode    = spa_mode_e'(ctl_r[1:0]);
   assign ren     = ctl_r[SPA_C_REN];
   assign parity_enable_bit     = ctl_r[SPA_C_PEN];
   assign sync    = (mode == SPA_M0);
   assign tk.baud = baud_r;
   assign tk.sync_mode = sync;
   assign tk.ext_edge  = ex_s2_r ^ ex_s3_r;

   spa_baud_gen u_gen
   (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .tk         (tk)
   );

   // ==========================================================
   // transmitter
   typedef enum {SPA_TX_IDLE, SPA_TX_RUN} spa_txst_e;
   spa_txst_e   tx_st_r, tx_st_nxt;
   logic [10:0] tsh_r, tsh_nxt;
   logic [3:0]  tbit_r, tbit_nxt, tnum;
   logic [3:0]  tov_r, tov_nxt;
   logic        tx_r, tx_nxt, tpend_r, tpend_nxt, tdone, tstop;
   logic        txpar, start_tx, ninth;

   // ==========================================================
   // receiver
   typedef enum {SPA_RX_IDLE, SPA_RX_RUN} spa_rxst_e;
   spa_rxst_e   rx_st_r, rx_st_nxt;
   logic [8:0]  rsh_r, rsh_nxt;
   logic [3:0]  rbit_r, rbit_nxt, rnum;
   logic [3:0]  rov_r, rov_nxt;
   logic        rdone, rferr, r9, samp, rpar;

   assign tnum = sync ? 4'h8 : ((mode == SPA_M1 && !parity_enable_bit) ? 4'hA : 4'hB);
   assign rnum = (mode == SPA_M1 && !parity_enable_bit) ? 4'hA : 4'hB;

   always_comb
   begin
      tx_st_nxt = tx_st_r;
      tsh_nxt   = tsh_r;
      tbit_nxt  = tbit_r;
      tov_nxt   = tov_r;
      tx_nxt    = tx_r;
      tpend_nxt = tpend_r;
      tdone     = 1'b0;
      tstop     = 1'b0;
      start_tx  = 1'b0;
      txpar     = ^txb_r ^ ctl_r[SPA_C_PAR];
      // parity replaces ninth bit in modes 2 and 3
      ninth     = parity_enable_bit ? txpar : ctl_r[SPA_C_TB8];
      if (wr && idx == SPA_IDX_TXBUF && (!sync || !ren))
         tpend_nxt = 1'b1;
      case (tx_st_r)
         SPA_TX_IDLE:
         begin
            tx_nxt = 1'b1;
            if (tpend_r)
            begin
               start_tx  = 1'b1;
               tpend_nxt = 1'b0;
               tx_st_nxt = SPA_TX_RUN;
               tbit_nxt  = 4'h0;
               tov_nxt   = 4'h0;
               if (sync)
                  tsh_nxt = {3'b111, txb_r};
               else if (mode == SPA_M1 && !parity_enable_bit)
                  tsh_nxt = {2'b11, txb_r, 1'b0};
               else if (mode == SPA_M1)
                  tsh_nxt = {1'b1, txpar, txb_r, 1'b0};
               else
                  tsh_nxt = {1'b1, ninth, txb_r, 1'b0};
               tx_nxt = sync ? txb_r[0] : 1'b0;
            end
         end
         SPA_TX_RUN:
         begin
            if (tk.tick)
            begin
               tov_nxt = tov_r + 4'h1;
               if ((sync && tov_r[0]) || (!sync && tov_r == SPA_OVS_LAST))
               begin
                  tov_nxt  = 4'h0;
                  tbit_nxt = tbit_r + 4'h1;
                  tsh_nxt  = {1'b1, tsh_r[10:1]};
                  tx_nxt   = sync ? tsh_r[1] : tsh_r[1];
                  if (!sync && tbit_r + 4'h2 == tnum)
                     tstop = 1'b1;
                  if (tbit_r + 4'h1 == tnum)
                  begin
                     tdone     = 1'b1;
                     tx_nxt    = 1'b1;
                     tx_st_nxt = SPA_TX_IDLE;
                     if (sync)
                        tstop = 1'b1;
                  end
               end
            end
         end
         default: tx_st_nxt = SPA_TX_IDLE;
      endcase
   end

   // mode 0 clock goes out on txd, data on the rx pin (driven while sending)
   assign txd_o    = !sync ? tx_r :
                     (tx_st_r == SPA_TX_RUN) ? ~tov_r[0] :
                     (rx_st_r == SPA_RX_RUN) ? ~rov_r[0] : 1'b1;
   assign rxd_o    = tx_r;
   assign rxd_oe_o = sync & (tx_st_r == SPA_TX_RUN);

   always_comb
   begin
      rx_st_nxt = rx_st_r;
      rsh_nxt   = rsh_r;
      rbit_nxt  = rbit_r;
      rov_nxt   = rov_r;
      rdone     = 1'b0;
      rferr     = 1'b0;
      samp      = 1'b0;
      r9        = 1'b0;
      rpar      = 1'b0;
      case (rx_st_r)
         SPA_RX_IDLE:
         begin
            // mode 0 starts on enable, async on falling edge
            if (ren && ((sync && tx_st_r == SPA_TX_IDLE) ||
                        (!sync && rx_s3_r && !rx_s2_r)))
            begin
               rx_st_nxt = SPA_RX_RUN;
               rbit_nxt  = 4'h0;
               rov_nxt   = 4'h0;
            end
         end
         SPA_RX_RUN:
         begin
            if (tk.tick)
            begin
               rov_nxt = rov_r + 4'h1;
               samp = sync ? rov_r[0] : (rov_r == SPA_OVS_MID);
               if (!sync && rov_r == SPA_OVS_LAST)
                  rov_nxt = 4'h0;
            end
            if (samp)
            begin
               rbit_nxt = rbit_r + 4'h1;
               if (sync)
               begin
                  rsh_nxt = {1'b0, rx_s2_r, rsh_r[7:1]};
                  if (rbit_r == 4'h7)
                  begin
                     rdone     = 1'b1;
                     rx_st_nxt = SPA_RX_IDLE;
                  end
               end
               else if (rbit_r == 4'h0 && rx_s2_r)
                  rx_st_nxt = SPA_RX_IDLE; // false start
               else if (rbit_r + 4'h1 == rnum)
               begin
                  rferr     = ~rx_s2_r;
                  rx_st_nxt = SPA_RX_IDLE;
               end
               else if (rbit_r != 4'h0)
               begin
                  rsh_nxt = (rnum == 4'hA) ? {1'b0, rx_s2_r, rsh_r[7:1]}
                                            : {rx_s2_r, rsh_r[8:1]};
                  if (rbit_r + 4'h2 == rnum)
                     rdone = 1'b1;
               end
            end
            if (!ren)
               rx_st_nxt = SPA_RX_IDLE;
         end
         default: rx_st_nxt = SPA_RX_IDLE;
      endcase
      r9   = (rnum == 4'hB) ? rsh_nxt[8] : 1'b0;
      rpar = ^rsh_nxt[7:0] ^ r9 ^ ctl_r[SPA_C_PAR];
   end

   // ==========================================================
   // register next state
   always_comb
   begin
      ctl_nxt    = ctl_r;
      baud_nxt   = baud_r;
      txb_nxt    = txb_r;
      rxb_nxt    = rxb_r;
      sts_nxt    = sts_r;
      prdata_nxt = prdata_r;
      // read data is latched in the setup cycle so it stands at the access
      // edge; a status read then clears only the flags it really reported
      if (psel && !penable && !pwrite)
      begin
         case (idx)
            SPA_IDX_STATUS:  prdata_nxt = {24'h000000, sts_r};
            SPA_IDX_CONTROL: prdata_nxt = {24'h000000, ctl_r};
            SPA_IDX_RXBUF:   prdata_nxt = {24'h000000, rxb_r};
            SPA_IDX_BAUD:    prdata_nxt = {16'h0000, baud_r};
            default:         prdata_nxt = 32'h00000000;
         endcase
      end
      if (rd && idx == SPA_IDX_STATUS)
         sts_nxt = sts_r & ~(prdata_r[7:0] & 8'hF4);
      if (wr)
      begin
         case (idx)
            SPA_IDX_CONTROL: ctl_nxt = {2'b00, pwdata[5:0]};
            SPA_IDX_BAUD:    baud_nxt = pwdata[15:0];
            SPA_IDX_TXBUF:
            begin
               txb_nxt = pwdata[7:0];
               sts_nxt[SPA_S_TXE] = 1'b0;
            end
            default: ;
         endcase
      end
      if (tdone)
         ctl_nxt[SPA_C_TB8] = 1'b0;
      if (tx_st_nxt == SPA_TX_IDLE && !tpend_nxt &&
          !(wr && idx == SPA_IDX_TXBUF))
         sts_nxt[SPA_S_TXE] = 1'b1;
      // hardware sets win over a same-cycle status read
      if (tstop)
         sts_nxt[SPA_S_TI] = 1'b1;
      if (rferr)
         sts_nxt[SPA_S_FE] = 1'b1;
      if (rdone)
      begin
         rxb_nxt = rsh_nxt[7:0];
         sts_nxt[SPA_S_RI] = 1'b1;
         if (sts_r[SPA_S_RI])
            sts_nxt[SPA_S_OE] = 1'b1;
         sts_nxt[SPA_S_RB8] = parity_enable_bit ? rpar : r9;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ctl_r    <= SPA_CONTROL_RST;
         sts_r    <= SPA_STATUS_RST;
         txb_r    <= 8'h00;
         rxb_r    <= 8'h00;
         baud_r   <= SPA_BAUD_RST;
         prdata_r <= 32'h00000000;
         tx_st_r  <= SPA_TX_IDLE;
         tsh_r    <= 11'h7FF;
         tbit_r   <= 4'h0;
         tov_r    <= 4'h0;
         tx_r     <= 1'b1;
         tpend_r  <= 1'b0;
         rx_st_r  <= SPA_RX_IDLE;
         rsh_r    <= 9'h000;
         rbit_r   <= 4'h0;
         rov_r    <= 4'h0;
      end
      else
      begin
         ctl_r    <= ctl_nxt;
         sts_r    <= sts_nxt;
         txb_r    <= txb_nxt;
         rxb_r    <= rxb_nxt;
         baud_r   <= baud_nxt;
         prdata_r <= prdata_nxt;
         tx_st_r  <= tx_st_nxt;
         tsh_r    <= tsh_nxt;
         tbit_r   <= tbit_nxt;
         tov_r    <= tov_nxt;
         tx_r     <= tx_nxt;
         tpend_r  <= tpend_nxt;
         rx_st_r  <= rx_st_nxt;
         rsh_r    <= rsh_nxt;
         rbit_r   <= rbit_nxt;
         rov_r    <= rov_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: spa_serial_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker
module spa_serial_port_monitor
   import spa_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic        rxd_oe_o,
   input  wire logic        txd_o
);
   localparam logic [31:0] A_ST = {14'h0, SPA_IDX_STATUS, 2'h0};
   localparam logic [31:0] A_TX = {14'h0, SPA_IDX_TXBUF, 2'h0};
   localparam logic [31:0] A_CT = {14'h0, SPA_IDX_CONTROL, 2'h0};
   localparam logic [31:0] A_RB = {14'h0, SPA_IDX_RXBUF, 2'h0};
   localparam logic [31:0] A_BD = {14'h0, SPA_IDX_BAUD, 2'h0};
   logic        acc;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic [1:0]  mode_r, mode_nxt;
   logic        ren_r, ren_nxt;
   logic [15:0] baud_r, baud_nxt;
   logic [3:0]  txw_r, txw_nxt;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign mapped = paddr inside {A_ST, A_TX, A_CT, A_RB, A_BD};
   // shadow of what software wrote; txw counts cycles since an async load
   always_comb
   begin
      mode_nxt = mode_r;
      ren_nxt = ren_r;
      baud_nxt = baud_r;
      txw_nxt = (txw_r != 4'h0 && txw_r != 4'hF) ? txw_r + 4'h1 : txw_r;
      if (wr && paddr == A_CT)
      begin
         mode_nxt = pwdata[1:0];
         ren_nxt = pwdata[SPA_C_REN];
      end
      if (wr && paddr == A_BD)
         baud_nxt = pwdata[15:0];
      if (wr && paddr == A_TX && mode_r != 2'h0)
         txw_nxt = 4'h1;
   end
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         mode_r <= SPA_CONTROL_RST[1:0];
         ren_r <= SPA_CONTROL_RST[SPA_C_REN];
         baud_r <= SPA_BAUD_RST;
         txw_r <= 4'h0;
      end
      else
      begin
         mode_r <= mode_nxt;
         ren_r <= ren_nxt;
         baud_r <= baud_nxt;
         txw_r <= txw_nxt;
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   // ==========================================================
   // assertions
   tx_start_a: assert property (wr && paddr == A_TX && mode_r != 2'h0 && txd_o
      |-> ##[1:80] !txd_o) else $error("async load did not start a frame");
   m0_refuse_a: assert property (wr && paddr == A_TX && mode_r == 2'h0 && ren_r
      |=> !rxd_oe_o [*8]) else $error("mode 0 load ran with receiver on");
   oe_mode_a: assert property (mode_r != 2'h0 |-> !rxd_oe_o)
      else $error("data pin driven outside mode 0");
   txe_clear_a: assert property (rd && paddr == A_ST && txw_r inside {[1:6]}
      |=> !prdata[SPA_S_TXE]) else $error("empty flag set after load");
   baud_read_a: assert property (rd && paddr == A_BD
      |=> prdata[15:0] == baud_r) else $error("baud read mismatch");
   bus_ready_a: assert property (acc |-> pready) else $error("no ready");
   unmapped_err_a: assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access without error");
   unmapped_zero_a: assert property (rd && !mapped |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   read_hold_a: assert property (!(psel && !penable && !pwrite)
      |=> $stable(prdata)) else $error("read data moved without a read");
   cover property (wr && paddr == A_TX && mode_r != 2'h0);
   cover property (wr && paddr == A_TX && mode_r == 2'h0 && ren_r);
   cover property (acc && !mapped);
endmodule
bind spa_serial_port spa_serial_port_monitor spa_serial_port_monitor_i (
   .core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rxd_oe_o(rxd_oe_o), .txd_o(txd_o));
`default_nettype wire

/* File: spa_remote_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far-end async transceiver
module spa_remote_peer
(
   input  wire logic core_clk_i,
   input  wire logic txd_i,
   output logic      rxd_o
);
   int         bit_cyc = 32;
   int         nb = 8;
   bit         cap_en = 1'b0;
   logic [8:0] got = 9'h0;
   logic       got_stop = 1'b0;
   int         cnt = 0;
   initial rxd_o = 1'b1;
   task automatic send(input logic [8:0] d, input int n, input logic stop);
      @(posedge core_clk_i);
      rxd_o <= 1'b0;
      repeat (bit_cyc) @(posedge core_clk_i);
      for (int i = 0; i < n; i++)
      begin
         rxd_o <= d[i];
         repeat (bit_cyc) @(posedge core_clk_i);
      end
      rxd_o <= stop;
      repeat (bit_cyc) @(posedge core_clk_i);
      rxd_o <= 1'b1;
   endtask
   // mid-bit sampling: a wrong bit period shows up as wrong data
   always
   begin
      @(negedge txd_i);
      if (cap_en)
      begin
         repeat (bit_cyc / 2) @(posedge core_clk_i);
         for (int i = 0; i < nb; i++)
         begin
            repeat (bit_cyc) @(posedge core_clk_i);
            got[i] = txd_i;
         end
         repeat (bit_cyc) @(posedge core_clk_i);
         got_stop = txd_i;
         cnt++;
      end
   end
endmodule
`default_nettype wire

/* File: spa_serial_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module spa_serial_port_test
   import spa_pkg::*;
;
   logic        core_clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pin_o;
   logic        pin_oe;
   logic        peer_tx;
   logic        txd;
   logic        rxd;
   logic        ext_clk = 1'b0;
   int          bad_count = 0;
   int          comparisons = 0;
   logic [31:0] v;
   logic        er;
   assign rxd = pin_oe ? pin_o : peer_tx;
   always #2 core_clk_i = ~core_clk_i;
   // timer pin at half the core rate, toggling away from rising core edges
   always #4 ext_clk = ~ext_clk;
   spa_serial_port spa_serial_port_i (.core_clk_i(core_clk_i),
      .rstn_i(rstn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd_i(rxd), .rxd_o(pin_o), .rxd_oe_o(pin_oe),
      .txd_o(txd), .ext_clk_i(ext_clk));
   spa_remote_peer spa_remote_peer_i (.core_clk_i(core_clk_i),
      .txd_i(txd), .rxd_o(peer_tx));
   // ==========================================================
   // bus and compare helpers
   task automatic apb(input logic w, input logic [15:0] idx,
                      input logic [31:0] d);
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      do @(posedge core_clk_i); while (pready !== 1'b1);
      er = pslverr;
      v = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, exp, mask, input string m);
      comparisons++;
      if ((got & mask) !== (exp & mask))
      begin
         bad_count++;
         $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("counts: %0d compared, %0d bad", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      apb(0, SPA_IDX_STATUS, 0);
      chk(v, 32'h0B, 32'hFF, "status reset");
      apb(0, SPA_IDX_CONTROL, 0);
      chk(v, 32'hC0, 32'hFF, "control reset");
      apb(0, SPA_IDX_BAUD, 0);
      chk(v, 32'h8000, 32'hFFFF, "baud reset");
      apb(0, 16'h1FF8, 0);
      chk({31'h0, er}, 32'h1, 32'h1, "unmapped error");
      $display("reset test done");
   endtask
   task automatic t_tx(input logic [15:0] bd, input spa_mode_e md,
      input logic [8:0] d, input logic parity_enable_bit, par, input int n,
      input logic [8:0] exp);
      int c0;
      int k;
      apb(1, SPA_IDX_BAUD, {16'h0, bd});
      spa_remote_peer_i.nb = n;
      spa_remote_peer_i.cap_en = 1'b1;
      apb(1, SPA_IDX_CONTROL, {26'h0, par, d[8], 1'b0, parity_enable_bit, md});
      c0 = spa_remote_peer_i.cnt;
      apb(1, SPA_IDX_TXBUF, {24'h0, d[7:0]});
      apb(0, SPA_IDX_STATUS, 0);
      chk(v, 32'h0, 32'h08, "empty flag after load");
      for (k = 0; k < 3000 && spa_remote_peer_i.cnt == c0; k++)
         @(posedge core_clk_i);
      repeat (40) @(posedge core_clk_i);
      chk(spa_remote_peer_i.cnt - c0, 1, 32'hFF, "one frame");
      chk({23'h0, spa_remote_peer_i.got}, {23'h0, exp}, 32'h1FF, "frame");
      chk({31'h0, spa_remote_peer_i.got_stop}, 32'h1, 32'h1, "stop");
      apb(0, SPA_IDX_STATUS, 0);
      chk(v, 32'h20, 32'h20, "tx done set");
      chk(v, 32'h08, 32'h08, "empty after frame");
      apb(0, SPA_IDX_STATUS, 0);
      chk(v, 32'h0, 32'h20, "tx done cleared");
      apb(0, SPA_IDX_CONTROL, 0);
      chk(v, 32'h0, 32'h10, "ninth bit cleared");
      $display("tx test mode %0d done", md);
   endtask
   task automatic t_rx(input spa_mode_e md, input logic ren, parity_enable_bit,
      input logic [8:0] d, input int n, input logic stop,
      input logic [7:0] st, msk);
      apb(1, SPA_IDX_CONTROL, {26'h0, 1'b0, 1'b0, ren, parity_enable_bit, md});
      apb(0, SPA_IDX_STATUS, 0);
      spa_remote_peer_i.send(d, n, stop);
      repeat (40) @(posedge core_clk_i);
      apb(0, SPA_IDX_STATUS, 0);
      chk(v, {24'h0, st}, {24'h0, msk}, "rx status");
      if (ren)
      begin
         apb(0, SPA_IDX_RXBUF, 0);
         chk(v, {24'h0, d[7:0]}, 32'hFF, "rx data");
      end
      apb(0, SPA_IDX_STATUS, 0);
      chk(v, 32'h0, 32'hD0, "flags cleared by read");
      $display("rx test mode %0d done", md);
   endtask
   task automatic t_overrun;
      apb(1, SPA_IDX_CONTROL, {28'h0, 2'h2, SPA_M1});
      apb(0, SPA_IDX_STATUS, 0);
      spa_remote_peer_i.send(9'h011, 8, 1'b1);
      spa_remote_peer_i.send(9'h022, 8, 1'b1);
      repeat (40) @(posedge core_clk_i);
      apb(0, SPA_IDX_STATUS, 0);
      chk(v, 32'h44, 32'h44, "overrun");
      apb(0, SPA_IDX_RXBUF, 0);
      chk(v, 32'h22, 32'hFF, "newest byte kept");
      $display("overrun test done");
   endtask
   task automatic t_mode0;
      int k;
      spa_remote_peer_i.cap_en = 1'b0;
      apb(1, SPA_IDX_BAUD, 32'h8002);
      apb(1, SPA_IDX_CONTROL, {28'h0, 2'h2, SPA_M0});
      apb(0, SPA_IDX_STATUS, 0);
      apb(1, SPA_IDX_TXBUF, 32'h5A);
      repeat (200) @(posedge core_clk_i);
      apb(0, SPA_IDX_STATUS, 0);
      chk(v, 32'h0, 32'h20, "mode 0 load refused");
      apb(1, SPA_IDX_CONTROL, {30'h0, SPA_M0});
      apb(1, SPA_IDX_TXBUF, 32'h5A);
      for (k = 0; k < 500 && pin_oe !== 1'b1; k++)
         @(posedge core_clk_i);
      chk({31'h0, pin_oe}, 32'h1, 32'h1, "mode 0 shifting");
      repeat (200) @(posedge core_clk_i);
      apb(0, SPA_IDX_STATUS, 0);
      chk(v, 32'h20, 32'h20, "mode 0 done");
      $display("mode 0 test done");
   endtask
   initial
   begin
      repeat (60000) @(posedge core_clk_i);
      bad_count++;
      $display("Error at %0t: watchdog expired", $time);
      give_verdict;
   end
   initial
   begin
      repeat (12) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      t_reset;
      t_tx(16'h8001, SPA_M1, 9'h0A5, 0, 0, 8, 9'h0A5);
      t_tx(16'h8001, SPA_M2, 9'h15A, 0, 0, 9, 9'h15A);
      t_tx(16'h8001, SPA_M3, 9'h0C1, 1, 0, 9, 9'h1C1);
      t_tx(16'h8001, SPA_M3, 9'h0C1, 1, 1, 9, 9'h0C1);
      t_tx(16'h0002, SPA_M1, 9'h03C, 0, 0, 8, 9'h03C);
      t_rx(SPA_M1, 1, 0, 9'h03C, 8, 1'b1, 8'h40, 8'h50);
      t_rx(SPA_M2, 1, 0, 9'h196, 9, 1'b1, 8'hC0, 8'hD0);
      t_rx(SPA_M3, 1, 1, 9'h196, 9, 1'b1, 8'hC0, 8'hC0);
      t_rx(SPA_M1, 1, 0, 9'h055, 8, 1'b0, 8'h50, 8'h50);
      t_rx(SPA_M1, 0, 0, 9'h055, 8, 1'b1, 8'h00, 8'h40);
      t_overrun;
      t_mode0;
      give_verdict;
   end
endmodule
`default_nettype wire
